// file: bbpm_top.v
// protection monitor of a four-switch buck-boost controller: sense limit
// comparators, overvoltage, power good, thermal, switch drive bits, monitor
// converter control. assumes an APB master on clk and pin inputs from
// analog comparators that are asynchronous to clk.
`timescale 1ns/1ps
`include "bbpm_defines.vh"
module bbpm_top
#(
  parameter PG_QUAL_CYC = `BBPM_PG_QUAL_CYC,
  parameter OV_ARM_CYC  = `BBPM_OV_ARM_CYC
)
(
  input  wire        clk,
  input  wire        reset,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        sense_first_over,
  input  wire        sense_second_over,
  input  wire        ov_compare,
  input  wire        pg_inner_ok,
  input  wire        pg_outer_ok,
  input  wire        thermal_trip,
  input  wire        slewing,
  input  wire        soft_start_done,
  input  wire        switch_cycle,
  input  wire [11:0] monitor_mv,
  input  wire        monitor_done,
  output reg  [1:0]  limit_select_first,
  output reg  [1:0]  limit_select_second,
  output reg         overcurrent_flag_out,
  output reg         converter_suspend,
  output reg         in_high_switch_off,
  output reg         in_low_switch_on,
  output reg         out_modulate_discharge,
  output reg         thermal_all_off,
  output reg         thermal_discharge,
  output reg         ov_freq_tick,
  output reg         ov_freq_override,
  output reg         power_good,
  output reg         int_out,
  output reg         bulk_cap_switch_ctl,
  output reg         pmos_drive_ctl,
  output reg  [1:0]  monitor_select,
  output reg         monitor_start
);

  // threshold in millivolts for a two-bit select
  function [11:0] lim_mv;
    input [1:0] s;
    begin
      case (s)
        2'h0:    lim_mv = `BBPM_LIM_MV0;
        2'h1:    lim_mv = `BBPM_LIM_MV1;
        2'h2:    lim_mv = `BBPM_LIM_MV2;
        default: lim_mv = `BBPM_LIM_MV3;
      endcase
    end
  endfunction

  localparam ST_IDLE = 2'h0;
  localparam ST_BUSY = 2'h1;

  // pin synchronisers, two flops each
  localparam NSYNC = 10;
  wire [NSYNC-1:0] raw;
  reg  [NSYNC-1:0] sync1;
  reg  [NSYNC-1:0] sync2;
  assign raw = {monitor_done, switch_cycle, soft_start_done, slewing,
                thermal_trip, pg_outer_ok, pg_inner_ok, ov_compare,
                sense_second_over, sense_first_over};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1)
    begin : g_sync
      always @(posedge clk or posedge reset)
      begin
        if (reset)
        begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
        end
        else
        begin
          sync1[gi] <= raw[gi];
          sync2[gi] <= sync1[gi];
        end
      end
    end
  endgenerate
  wire s_cs1   = sync2[0];
  wire s_cs2   = sync2[1];
  wire s_ov    = sync2[2];
  wire s_in    = sync2[3];
  wire s_out   = sync2[4];
  wire s_temp  = sync2[5];
  wire s_slew  = sync2[6];
  wire s_ssd   = sync2[7];
  wire s_cyc   = sync2[8];
  wire s_mdone = sync2[9];
  // sample value is a bus from a converter that holds it while done is up
  reg  [11:0] mv_hold;
  wire [11:0] mv_code = mv_hold / `BBPM_STEP_MV;
  reg         mdone_d;
  reg         fault_d;

  // registers
  reg  [8:0]  ctrl;
  reg  [3:0]  mask;
  reg  [3:0]  fault;
  reg  [4:0]  conv;
  reg  [6:0]  sample;
  reg         pg_reg;
  reg         ov_active;
  reg         ov_armed;
  reg         ov_hit;
  reg         pg_out_hit;
  reg         startup;
  reg         latched;
  reg         temp_seen;
  reg  [31:0] pg_cnt;
  reg  [31:0] arm_cnt;
  reg  [15:0] div_cnt;
  reg  [1:0]  mstate;
  reg         ssd_d;

  wire wr  = psel & penable & pwrite;
  wire rd  = psel & penable & ~pwrite;
  wire hit_ctrl  = paddr == `BBPM_REG_CTRL;
  wire hit_mask  = paddr == `BBPM_REG_MASK;
  wire hit_fault = paddr == `BBPM_REG_FAULT;
  wire hit_stat  = paddr == `BBPM_REG_STATUS;
  wire hit_conv  = paddr == `BBPM_REG_CONV;
  wire hit_samp  = paddr == `BBPM_REG_SAMPLE;
  wire hit_lim   = paddr == `BBPM_REG_LIMIT;
  wire mapped = hit_ctrl | hit_mask | hit_fault | hit_stat | hit_conv
              | hit_samp | hit_lim;

  // events; an overvoltage must still stand at the next cycle marker, so
  // a compare shorter than one switching cycle never counts
  wire ext_trip = s_cs1 | s_cs2;
  wire ov_ev  = ov_hit & s_cyc & ov_armed & ~s_slew
              & ~mask[`BBPM_MSK_OV];
  wire pg_low = pg_reg & pg_out_hit & s_cyc;
  wire any_fault = ov_ev | pg_low | s_temp | ext_trip;

  // apb slave: zero wait states, error on unmapped address
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= 32'h00000000;
      if (psel & ~penable & ~pwrite)
      begin
        if (hit_ctrl)  prdata <= {23'h000000, ctrl};
        if (hit_mask)  prdata <= {28'h0000000, mask};
        if (hit_fault) prdata <= {28'h0000000, fault};
        if (hit_stat)  prdata <= {26'h0000000, latched, startup, ov_active,
                                  s_temp, ext_trip, pg_reg};
        if (hit_conv)  prdata <= {27'h0000000, conv};
        if (hit_samp)  prdata <= {25'h0000000, sample};
        if (hit_lim)   prdata <= {4'h0, lim_mv(ctrl[`BBPM_CTRL_LIM2]),
                                  4'h0, lim_mv(ctrl[`BBPM_CTRL_LIM1])};
      end
    end
  end

  // control and mask registers; restart bit self-clears
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ctrl <= `BBPM_CTRL_RST;
      mask <= `BBPM_MASK_RST;
    end
    else
    begin
      ctrl[`BBPM_CTRL_RESTART] <= 1'b0;
      if (wr & pready & hit_ctrl)
        ctrl <= pwdata[8:0];
      if (wr & pready & hit_mask)
        mask <= pwdata[3:0];
    end
  end

  // fault register: sticky, set wins, cleared only by writing one to the bit
  always @(posedge clk or posedge reset)
  begin
    if (reset)
      fault <= 4'h0;
    else
      fault <= (fault & ~((wr & pready & hit_fault) ? pwdata[3:0] : 4'h0))
             | {ext_trip, s_temp, pg_low, ov_ev};
  end

  // overvoltage: needs compare across a full switching cycle
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ov_hit    <= 1'b0;
      ov_active <= 1'b0;
      ov_armed  <= 1'b0;
      arm_cnt   <= 32'h00000000;
      ssd_d     <= 1'b0;
    end
    else
    begin
      ssd_d <= s_ssd;
      if (!s_ov)
        ov_hit <= 1'b0;
      else if (s_cyc)
        ov_hit <= 1'b1;
      if (s_slew | ~s_ssd)
      begin
        ov_armed <= 1'b0;
        arm_cnt  <= 32'h00000000;
      end
      else if (!ov_armed)
      begin
        if (arm_cnt >= OV_ARM_CYC - 1)
          ov_armed <= 1'b1;
        arm_cnt <= arm_cnt + 32'h00000001;
      end
      if (mask[`BBPM_MSK_OV])
        ov_active <= 1'b0;
      else if (ov_ev)
        ov_active <= 1'b1;
      else if (!s_ov)
        ov_active <= 1'b0;
    end
  end

  // power good: qualify inner window, drop on wide window miss
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pg_reg     <= 1'b0;
      pg_cnt     <= 32'h00000000;
      pg_out_hit <= 1'b0;
      startup    <= 1'b1;
    end
    else
    begin
      if (s_out)
        pg_out_hit <= 1'b0;
      else if (s_cyc)
        pg_out_hit <= 1'b1;
      if (!s_in)
        pg_cnt <= 32'h00000000;
      else if (pg_cnt < PG_QUAL_CYC)
        pg_cnt <= pg_cnt + 32'h00000001;
      if (mask[`BBPM_MSK_PG])
        pg_reg <= 1'b0;
      else if (pg_low)
        pg_reg <= 1'b0;
      else if (s_in && pg_cnt >= PG_QUAL_CYC - 1)
      begin
        pg_reg  <= 1'b1;
        startup <= 1'b0;
      end
    end
  end

  // overcurrent flag, latch, thermal, switch drive and interrupt outputs
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      overcurrent_flag_out   <= 1'b0;
      latched                <= 1'b0;
      converter_suspend      <= 1'b0;
      temp_seen              <= 1'b0;
      thermal_all_off        <= 1'b0;
      thermal_discharge      <= 1'b0;
      in_high_switch_off     <= 1'b0;
      in_low_switch_on       <= 1'b0;
      out_modulate_discharge <= 1'b0;
      ov_freq_override       <= 1'b0;
      power_good             <= 1'b0;
      int_out                <= 1'b0;
      limit_select_first     <= 2'h0;
      limit_select_second    <= 2'h0;
      bulk_cap_switch_ctl    <= 1'b0;
      pmos_drive_ctl         <= 1'b0;
    end
    else
    begin
      overcurrent_flag_out <= ext_trip;
      limit_select_first   <= ctrl[`BBPM_CTRL_LIM1];
      limit_select_second  <= ctrl[`BBPM_CTRL_LIM2];
      // a trip in the restart cycle wins: the fault is still there
      if (ext_trip & ctrl[`BBPM_CTRL_LATCH])
        latched <= 1'b1;
      else if (ctrl[`BBPM_CTRL_RESTART])
        latched <= 1'b0;
      converter_suspend <= latched | (ext_trip & ctrl[`BBPM_CTRL_LATCH]);
      // thermal: all off while hot, discharge once cooled
      if (s_temp)
        temp_seen <= 1'b1;
      else if (ctrl[`BBPM_CTRL_RESTART])
        temp_seen <= 1'b0;
      thermal_all_off   <= s_temp;
      thermal_discharge <= temp_seen & ~s_temp;
      // thermal off overrides the overvoltage drive pattern
      in_high_switch_off     <= ov_active | s_temp;
      in_low_switch_on       <= ov_active & ~s_temp;
      out_modulate_discharge <= ov_active & ~s_temp;
      ov_freq_override       <= ov_active;
      power_good <= pg_reg;
      // pin shows power good state inverted during startup when selected
      int_out <= (|(fault & ~mask))
               | (ctrl[`BBPM_CTRL_PGINT] & startup
                  & ~mask[`BBPM_MSK_PG]);
      bulk_cap_switch_ctl <= ctrl[`BBPM_CTRL_BULK];
      pmos_drive_ctl      <= ctrl[`BBPM_CTRL_PMOS];
    end
  end

  // fixed 50 kHz tick used in place of the programmed frequency
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      div_cnt      <= 16'h0000;
      ov_freq_tick <= 1'b0;
    end
    else
    begin
      ov_freq_tick <= 1'b0;
      if (!ov_active)
        div_cnt <= 16'h0000;
      else if (div_cnt == `BBPM_OV_DIV_CYC - 1)
      begin
        div_cnt      <= 16'h0000;
        ov_freq_tick <= 1'b1;
      end
      else
        div_cnt <= div_cnt + 16'h0001;
    end
  end

  // monitor converter: select, trigger modes and sample coding
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      conv           <= 5'h00;
      mstate         <= ST_IDLE;
      monitor_start  <= 1'b0;
      monitor_select <= 2'h0;
      sample         <= 7'h00;
      mv_hold        <= 12'h000;
      mdone_d        <= 1'b0;
      fault_d        <= 1'b0;
    end
    else
    begin
      monitor_start <= 1'b0;
      conv[`BBPM_CONV_GO] <= 1'b0;
      // edge detectors: a lasting thermal or sense trip asks one read, a lasting overvoltage asks at each cycle marker; a done tail is stale
      mdone_d <= s_mdone;
      fault_d <= any_fault;
      if (wr & pready & hit_conv)
        conv <= pwdata[4:0];
      monitor_select <= conv[`BBPM_CONV_SEL];
      case (mstate)
        ST_IDLE:
        begin
          if ((conv[`BBPM_CONV_TRIG] == `BBPM_TRIG_FAULT
               & any_fault & ~fault_d)
              | (conv[`BBPM_CONV_TRIG] == `BBPM_TRIG_ONCE
                 & conv[`BBPM_CONV_GO])
              | (conv[`BBPM_CONV_TRIG] == `BBPM_TRIG_CONT))
          begin
            monitor_start <= 1'b1;
            mstate        <= ST_BUSY;
          end
        end
        ST_BUSY:
        begin
          if (s_mdone & ~mdone_d)
          begin
            mv_hold <= monitor_mv;
            mstate  <= ST_IDLE;
          end
        end
        default: mstate <= ST_IDLE;
      endcase
      // unsigned code of voltage over step, clamped at top code
      if (|mv_code[11:7])
        sample <= `BBPM_TOP_CODE;
      else
        sample <= mv_code[6:0];
    end
  end

endmodule

// file: bbpm_defines.vh
// register offsets, field positions, reset values and timing counts
// for the protection monitor; included by bbpm_top.v
`ifndef BBPM_DEFINES_VH
`define BBPM_DEFINES_VH
`define BBPM_CLK_HZ        10000000
`define BBPM_REG_CTRL      12'h000
`define BBPM_REG_MASK      12'h004
`define BBPM_REG_FAULT     12'h008
`define BBPM_REG_STATUS    12'h00C
`define BBPM_REG_CONV      12'h010
`define BBPM_REG_SAMPLE    12'h014
`define BBPM_REG_LIMIT     12'h018
// ctrl fields
`define BBPM_CTRL_LIM1     1:0
`define BBPM_CTRL_LIM2     3:2
`define BBPM_CTRL_LATCH    4
`define BBPM_CTRL_BULK     5
`define BBPM_CTRL_PMOS     6
`define BBPM_CTRL_PGINT    7
`define BBPM_CTRL_RESTART  8
`define BBPM_CTRL_RST      9'h000
// mask fields
`define BBPM_MSK_OV        0
`define BBPM_MSK_PG        1
`define BBPM_MSK_TEMP      2
`define BBPM_MSK_EXTOC     3
`define BBPM_MASK_RST      4'h0
// fault fields
`define BBPM_FLT_OV        0
`define BBPM_FLT_PG        1
`define BBPM_FLT_TEMP      2
`define BBPM_FLT_EXTOC     3
// converter control fields
`define BBPM_CONV_SEL      1:0
`define BBPM_CONV_TRIG     3:2
`define BBPM_CONV_GO       4
`define BBPM_TRIG_FAULT    2'h0
`define BBPM_TRIG_ONCE     2'h1
`define BBPM_TRIG_CONT     2'h2
`define BBPM_SEL_FB        2'h0
`define BBPM_SEL_VIN       2'h1
`define BBPM_SEL_CS2       2'h2
`define BBPM_SEL_CS1       2'h3
// thresholds in millivolts
`define BBPM_LIM_MV0       12'h0FA
`define BBPM_LIM_MV1       12'h2EE
`define BBPM_LIM_MV2       12'h5DC
`define BBPM_LIM_MV3       12'h9C4
`define BBPM_STEP_MV       12'h014
`define BBPM_TOP_CODE      7'h7F
// times
`define BBPM_PG_QUAL_US    3300
`define BBPM_OV_ARM_US     1000
`define BBPM_OV_FREQ_HZ    50000
`define BBPM_PG_QUAL_CYC   ((`BBPM_PG_QUAL_US * (`BBPM_CLK_HZ / 1000000)))
`define BBPM_OV_ARM_CYC    ((`BBPM_OV_ARM_US * (`BBPM_CLK_HZ / 1000000)))
`define BBPM_OV_DIV_CYC    (`BBPM_CLK_HZ / `BBPM_OV_FREQ_HZ)
`endif

// file: bbpm_checker.sv
// checker for the protection monitor: timing relations at the top ports
// assumes a bind into bbpm_top, one clock and an async active-high reset
`timescale 1ns/1ps
module bbpm_checker
#(
  parameter PG_QUAL_CYC = 33000,
  parameter OV_ARM_CYC  = 10000
)
(
  input logic clk,
  input logic reset,
  input logic sense_first_over,
  input logic sense_second_over,
  input logic ov_compare,
  input logic pg_inner_ok,
  input logic pg_outer_ok,
  input logic thermal_trip,
  input logic slewing,
  input logic soft_start_done,
  input logic switch_cycle,
  input logic overcurrent_flag_out,
  input logic in_high_switch_off,
  input logic in_low_switch_on,
  input logic out_modulate_discharge,
  input logic thermal_all_off,
  input logic ov_freq_tick,
  input logic ov_freq_override,
  input logic power_good,
  input logic monitor_start
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  int   ok_run;
  int   arm_run;
  int   ov_run;
  int   out_sw;
  int   tick_gap;
  logic tick_seen;
  // run lengths counted at the pins; the design sees them two edges late,
  // so its own counts can only be shorter than these
  always @(posedge clk or posedge reset)
    if (reset)
    begin
      ok_run    <= 0;
      arm_run   <= 0;
      ov_run    <= 0;
      out_sw    <= 0;
      tick_gap  <= 0;
      tick_seen <= 1'b0;
    end
    else
    begin
      ok_run    <= pg_inner_ok ? ok_run + 1 : 0;
      arm_run   <= (soft_start_done && !slewing) ? arm_run + 1 : 0;
      ov_run    <= ov_compare ? ov_run + switch_cycle : 0;
      out_sw    <= pg_outer_ok ? 0 : out_sw + switch_cycle;
      tick_gap  <= (ov_freq_tick || !ov_freq_override) ? 0 : tick_gap + 1;
      tick_seen <= ov_freq_override && (tick_seen || ov_freq_tick);
    end

  ov_persist_a: assert property ($rose(ov_freq_override)
    |-> ov_run >= 2)
    else $error("overvoltage raised within one switching cycle");
  ov_drive_a: assert property (ov_freq_override |-> in_high_switch_off
    && in_low_switch_on && out_modulate_discharge)
    else $error("overvoltage switch drive wrong");
  ov_tick_a: assert property (ov_freq_tick && tick_seen |-> tick_gap == 199)
    else $error("fixed rate tick spacing wrong");
  ov_arm_a: assert property ($rose(ov_freq_override) |->
    arm_run >= OV_ARM_CYC)
    else $error("overvoltage raised while blanked");
  oc_flag_a: assert property ((sense_first_over || sense_second_over)[*5]
    |-> overcurrent_flag_out)
    else $error("overcurrent flag missing");
  pg_qual_a: assert property ($rose(power_good) |-> ok_run >= PG_QUAL_CYC)
    else $error("power good before qualification");
  pg_drop_a: assert property (out_sw >= 4 |-> !power_good)
    else $error("power good kept outside wide window");
  therm_off_a: assert property (thermal_trip[*5] |-> thermal_all_off)
    else $error("switches not off on thermal trip");
  start_pulse_a: assert property (monitor_start |=> !monitor_start)
    else $error("conversion start longer than one cycle");
  cover property ($rose(power_good));
  cover property (ov_freq_tick && tick_seen);
  cover property (monitor_start);
endmodule

bind bbpm_top bbpm_checker #(
  .PG_QUAL_CYC(PG_QUAL_CYC),
  .OV_ARM_CYC(OV_ARM_CYC)
) bbpm_checker_inst (
  .clk, .reset, .sense_first_over, .sense_second_over, .ov_compare,
  .pg_inner_ok, .pg_outer_ok, .thermal_trip, .slewing, .soft_start_done,
  .switch_cycle, .overcurrent_flag_out, .in_high_switch_off,
  .in_low_switch_on, .out_modulate_discharge, .thermal_all_off,
  .ov_freq_tick, .ov_freq_override, .power_good, .monitor_start
);

// file: bbpm_front_model.sv
// front-end model: analog mux and sampling converter beside the monitor
// assumes start pulses on clk; answers after a random wait of 2..7 clocks
`timescale 1ns/1ps
module bbpm_front_model
(
  input  logic        clk,
  input  logic        reset,
  input  logic        monitor_start,
  input  logic [1:0]  monitor_select,
  input  logic [47:0] chan_mv,
  output logic [11:0] monitor_mv,
  output logic        monitor_done
);
  logic [1:0] sel;
  logic       busy;
  int         wait_cnt;
  int         hold;
  // result held while done is high, then scrambled so a late capture fails
  always @(posedge clk or posedge reset)
    if (reset)
    begin
      busy         <= 1'b0;
      sel          <= 2'h0;
      wait_cnt     <= 0;
      hold         <= 0;
      monitor_done <= 1'b0;
      monitor_mv   <= 12'h000;
    end
    else if (monitor_start)
    begin
      busy     <= 1'b1;
      sel      <= monitor_select;
      wait_cnt <= 2 + $urandom % 6;
    end
    else if (busy && wait_cnt > 0)
      wait_cnt <= wait_cnt - 1;
    else if (busy)
    begin
      busy         <= 1'b0;
      hold         <= 4;
      monitor_done <= 1'b1;
      monitor_mv   <= chan_mv[sel * 12 +: 12];
    end
    else if (hold > 0)
    begin
      hold         <= hold - 1;
      monitor_done <= hold > 1;
      monitor_mv   <= hold > 1 ? monitor_mv : ~monitor_mv;
    end
endmodule

// file: tb.sv
// self-checking bench for the protection monitor over APB
// assumes bbpm_top, its defines header and the front-end model
`timescale 1ns/1ps
`include "bbpm_defines.vh"
module tb;
  localparam PGQ = 50;
  localparam OVA = 20;
  localparam CT = `BBPM_REG_CTRL, MK = `BBPM_REG_MASK;
  localparam FL = `BBPM_REG_FAULT, CV = `BBPM_REG_CONV;
  logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0, monitor_mv;
  logic [31:0] pwdata = 0, prdata, q, v;
  logic [47:0] chan_mv = 0;
  logic [1:0] sc = 0, limit_select_first, limit_select_second, monitor_select;
  logic sense_first_over = 0, sense_second_over = 0, ov_compare = 0;
  logic pg_inner_ok = 0, pg_outer_ok = 0, thermal_trip = 0, slewing = 0;
  logic soft_start_done = 0, switch_cycle = 0, pready, pslverr, perr;
  logic monitor_done, overcurrent_flag_out, converter_suspend;
  logic in_high_switch_off, in_low_switch_on, out_modulate_discharge;
  logic thermal_all_off, thermal_discharge, ov_freq_tick, ov_freq_override;
  logic power_good, int_out, bulk_cap_switch_ctl, pmos_drive_ctl;
  logic monitor_start;
  logic [6:0] mon;
  int mismatches = 0, comparisons = 0, starts = 0, n0, m;
  int lim_tab[4] = '{250, 750, 1500, 2500};
  int exp_q[$];
  assign mon = {int_out, thermal_discharge, thermal_all_off, power_good,
                ov_freq_override, converter_suspend, overcurrent_flag_out};

  bbpm_top #(.PG_QUAL_CYC(PGQ), .OV_ARM_CYC(OVA)) bbpm_top_inst (
    .clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .sense_first_over, .sense_second_over, .ov_compare,
    .pg_inner_ok, .pg_outer_ok, .thermal_trip, .slewing, .soft_start_done,
    .switch_cycle, .monitor_mv, .monitor_done, .limit_select_first,
    .limit_select_second, .overcurrent_flag_out, .converter_suspend,
    .in_high_switch_off, .in_low_switch_on, .out_modulate_discharge,
    .thermal_all_off, .thermal_discharge, .ov_freq_tick, .ov_freq_override,
    .power_good, .int_out, .bulk_cap_switch_ctl, .pmos_drive_ctl,
    .monitor_select, .monitor_start);
  bbpm_front_model bbpm_front_model_inst (.clk, .reset, .monitor_start,
    .monitor_select, .chan_mv, .monitor_mv, .monitor_done);

  always #50 clk = ~clk;
  // switching cycle marker every fourth clock; conversions counted here
  always @(posedge clk)
  begin
    sc <= sc + 1;
    switch_cycle <= sc == 0;
    if (monitor_start === 1'b1)
      starts++;
  end

  task chk(input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: %h, expected %h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // one transfer; the master holds everything until pready is seen high
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    q = prdata;
    perr = pslverr;
    psel <= 0;
    penable <= 0;
    chk(pready, 1);
    if (pready !== 1'b1)
      end_of_test;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] mk, e);
    apb(0, a, 0);
    chk(q & mk, e);
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // bounded wait for one watched output; running out ends the run
  task wait_bit(input int i, input logic b, input int lim);
    int n;
    n = 0;
    while (mon[i] !== b && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    chk(mon[i], b);
    if (mon[i] !== b)
      end_of_test;
  endtask

  initial
  begin
    repeat (100000) @(posedge clk);
    mismatches++;
    end_of_test;
  end

  initial
  begin
    void'($urandom(32'h6FF2D6C4));
    repeat (6) @(posedge clk);
    reset <= 0;
    @(negedge clk);
    chk({limit_select_first, limit_select_second}, 0);
    chk({bulk_cap_switch_ctl, pmos_drive_ctl}, 0);
    rd(`BBPM_REG_LIMIT, '1, 250 | 250 << 16);
    // every threshold code on both comparators, random drive bits
    for (int k = 0; k < 4; k++)
    begin
      v = ($urandom & 32'h60) | (3 - k) << 2 | k;
      wr(CT, v);
      cyc(2);
      chk({limit_select_first, limit_select_second}, k << 2 | 3 - k);
      chk({pmos_drive_ctl, bulk_cap_switch_ctl}, v[6:5]);
      rd(`BBPM_REG_LIMIT, '1, lim_tab[k] | lim_tab[3 - k] << 16);
    end
    // unmapped offset: error answer, read zero, no side effect
    wr(12'h0FC, 32'h1);
    chk(perr, 1);
    rd(12'h0FC, '1, 0);
    rd(CT, '1, v);
    wr(CT, 0);
    // plain trip: flag follows the comparator, sticky until cleared
    @(posedge clk) sense_first_over <= 1;
    wait_bit(0, 1, 10);
    chk(converter_suspend, 0);
    @(posedge clk) sense_first_over <= 0;
    wait_bit(0, 0, 10);
    rd(FL, 8, 8);
    rd(FL, 8, 8);
    wr(FL, 8);
    rd(FL, 8, 0);
    // latching mode holds suspension until restart
    wr(CT, 32'h10);
    @(posedge clk) sense_second_over <= 1;
    wait_bit(0, 1, 10);
    wait_bit(1, 1, 10);
    @(posedge clk) sense_second_over <= 0;
    cyc(10);
    chk(converter_suspend, 1);
    rd(`BBPM_REG_STATUS, 32'h20, 32'h20);
    wr(CT, 32'h110);
    wait_bit(1, 0, 10);
    wr(FL, 32'hF);
    // overvoltage blanked while slewing, rearmed after settling
    @(posedge clk);
    soft_start_done <= 1;
    slewing <= 1;
    ov_compare <= 1; // trips by intent, no low target is ever set
    cyc(OVA + 20);
    chk(ov_freq_override, 0);
    @(posedge clk) slewing <= 0;
    cyc(OVA - 4);
    chk(ov_freq_override, 0);
    wait_bit(2, 1, 40);
    chk({in_high_switch_off, in_low_switch_on, out_modulate_discharge}, 7);
    cyc(450);
    rd(FL, 1, 1);
    rd(`BBPM_REG_STATUS, 8, 8);
    @(posedge clk) ov_compare <= 0;
    wait_bit(2, 0, 40);
    wr(FL, 1);
    wr(MK, 1);
    @(posedge clk) ov_compare <= 1;
    cyc(40);
    chk(ov_freq_override, 0);
    rd(FL, 1, 0);
    @(posedge clk) ov_compare <= 0;
    wr(MK, 0);
    // power good qualification, inner loss kept, wide loss clears
    wr(CT, 32'h80);
    wait_bit(6, 1, 5);
    @(posedge clk);
    pg_inner_ok <= 1;
    pg_outer_ok <= 1;
    cyc(PGQ / 2);
    chk(power_good, 0);
    wait_bit(3, 1, PGQ);
    chk(int_out, 0);
    @(posedge clk) pg_inner_ok <= 0;
    cyc(20);
    chk(power_good, 1);
    @(posedge clk) pg_outer_ok <= 0;
    wait_bit(3, 0, 20);
    wr(MK, 2);
    @(posedge clk);
    pg_inner_ok <= 1;
    pg_outer_ok <= 1;
    cyc(PGQ + 20);
    chk(power_good, 0);
    @(posedge clk);
    pg_inner_ok <= 0;
    pg_outer_ok <= 0;
    wr(MK, 0);
    wr(FL, 32'hF);
    // thermal trip, interrupt, masking and clearing
    n0 = starts;
    @(posedge clk) thermal_trip <= 1;
    wait_bit(4, 1, 10);
    wait_bit(6, 1, 10);
    rd(FL, 4, 4);
    chk(starts - n0, 1);
    @(posedge clk) thermal_trip <= 0;
    wait_bit(5, 1, 10);
    wr(MK, 4);
    wait_bit(6, 0, 5);
    wr(MK, 0);
    wait_bit(6, 1, 5);
    wr(FL, 4);
    wait_bit(6, 0, 5);
    wr(CT, 32'h100);
    wait_bit(5, 0, 10);
    // one read per command on every input, top channel saturates
    @(posedge clk) chan_mv <= {12'hBB8, 12'($urandom % 2600),
                               12'($urandom % 2600), 12'($urandom % 2600)};
    wr(CV, 0);
    for (int s = 0; s < 4; s++)
    begin
      n0 = starts;
      wr(CV, 32'h14 | s);
      cyc(20);
      chk(starts - n0, 1);
      chk(monitor_select, s);
      m = chan_mv[s * 12 +: 12];
      exp_q.push_back(m / 20 > 127 ? 127 : m / 20);
      rd(`BBPM_REG_SAMPLE, '1, exp_q.pop_front());
    end
    wr(CV, 0);
    n0 = starts;
    wr(CV, 32'h18);
    cyc(200);
    chk(starts - n0 > 2, 1);
    wr(CV, 0);
    end_of_test;
  end
endmodule
